//--- hdl/lce_edge_eval.sv
// Edge pulse evaluation from previous and current execution condition
`timescale 1ns/1ps
`default_nettype none
module lce_edge_eval (
  input  wire logic falling, // High for the falling-edge form
  input  wire logic prev,    // Stored previous condition
  input  wire logic cur,     // Current condition
  output logic      pulse    // Designated bit value
);

  always_comb begin
    if (falling) begin
      pulse = prev & ~cur;     // [RULE1] [RULE2]
    end else begin
      pulse = ~prev & cur;     // [RULE4]
    end
  end

endmodule
`default_nettype wire

//--- hdl/lce_mem.sv
// Simple dual-port memory with registered read data and no reset
`timescale 1ns/1ps
`default_nettype none
module lce_mem #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned AW    = 8
) (
  input  wire logic             clk,     // Clock
  input  wire logic             wr_en,   // Write strobe
  input  wire logic [AW-1:0]    wr_addr, // Write address
  input  wire logic [WIDTH-1:0] wr_data, // Write data
  input  wire logic [AW-1:0]    rd_addr, // Read address
  output var  logic [WIDTH-1:0] rd_data  // Read data, one cycle later
);

  logic [WIDTH-1:0] mem [0:(1<<AW)-1];

  // Contents survive reset; the owner clears what must not be retained
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule
`default_nettype wire

//--- hdl/lce_pkg.sv
// Shared constants and types for the ladder edge, latch and interlock unit
package lce_pkg;

  localparam int unsigned DEF_BIT_AW   = 8;      // Bit memory address width
  localparam int unsigned DEF_SLOT_AW  = 5;      // Edge history slot address width
  localparam int unsigned DEF_TC_AW    = 4;      // Timer/counter number width
  localparam logic [7:0]  DEF_RETAIN_BASE = 8'hc0; // First retentive data bit address

  localparam logic        BIT_OFF = 1'h0;
  localparam logic        BIT_ON  = 1'h1;

  typedef enum logic [3:0] {
    OP_OTHER        = 4'h0,
    OP_OUT          = 4'h1,
    OP_OUT_NOT      = 4'h2,
    OP_LATCH        = 4'h3,
    OP_RISE_PULSE   = 4'h4,
    OP_FALL_PULSE   = 4'h5,
    OP_SECTION_LOCK = 4'h6,
    OP_SECTION_UNLK = 4'h7,
    OP_DELAY_TIMER  = 4'h8,
    OP_DOWN_COUNTER = 4'h9
  } lce_op_t;

  typedef enum logic [1:0] {
    TC_RUN    = 2'h0,
    TC_RESET  = 2'h1,
    TC_FREEZE = 2'h2
  } lce_tc_cmd_t;

  typedef enum logic [0:0] {
    PH_SWEEP = 1'h0,
    PH_RUN   = 1'h1
  } lce_phase_t;

endpackage

//--- hdl/lce_unit.sv
// Instruction executor for edge pulses, latching bits and interlocked sections
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// (RULE1) Fall pulse ON when previous ON, current OFF
// (RULE2) Fall pulse OFF when previous was OFF
// (RULE3) Pulse bits stay ON one scan at most; the unit leaves them ON for as long as their section is locked
// (RULE4) Rise pulse ON once per OFF-to-ON transition
// (RULE5) Latch set turns bit ON and holds
// (RULE6) Latch reset turns bit OFF and holds
// (RULE7) Set and reset together: reset wins
// (RULE8) Latch bits keep status while interlocked
// (RULE9) Retentive latch bits survive power loss
// (RULE10) Latch operand only output, work, retentive, link
// (RULE11) Lock condition ON: section runs as written
// (RULE12) Locked section outputs forced OFF
// (RULE13) Locked section timers reset to set value
// (RULE14) Locked section counters freeze present value
// (RULE15) Other locked instructions, pulses, not executed
// (RULE16) Each lock opens section to next unlock
// (RULE17) Program pairs locks with following unlock
// (RULE18) Unlock cancels all locks since last unlock
// (RULE19) Locked pulses do not record condition changes
// (RULE20) After lock, compare with pre-lock stored value
// (RULE21) No step instructions inside locked section
// (RULE22) These instructions change no flags
// (RULE23) Output follows condition; inverted form opposite
module lce_unit #(
  parameter int unsigned BIT_AW      = lce_pkg::DEF_BIT_AW,
  parameter int unsigned SLOT_AW     = lce_pkg::DEF_SLOT_AW,
  parameter int unsigned TC_AW       = lce_pkg::DEF_TC_AW,
  parameter logic [BIT_AW-1:0] RETAIN_BASE = BIT_AW'(lce_pkg::DEF_RETAIN_BASE)
) (
  input  wire logic               sys_clk,        // Clock, 100 MHz
  input  wire logic               resetn,         // Synchronous reset, active low
  input  wire logic               instr_valid,    // Instruction offered
  output logic                    instr_ready,    // Instruction taken when valid
  input  wire lce_pkg::lce_op_t   instr_op,       // Instruction kind
  input  wire logic               instr_cond,     // Execution (or set) condition
  input  wire logic               instr_cond_rst, // Reset condition of latch
  input  wire logic [BIT_AW-1:0]  instr_bit,      // Designated bit address
  input  wire logic [SLOT_AW-1:0] instr_slot,     // Edge history slot
  input  wire logic [TC_AW-1:0]   instr_tc,       // Timer/counter number
  output logic                    instr_exec,     // Other instruction may execute
  input  wire logic [BIT_AW-1:0]  bit_rd_addr,    // Bit read address
  output logic                    bit_rd_data,    // Bit read data, one cycle later
  output logic                    tc_cmd_valid,   // Timer/counter command strobe
  output lce_pkg::lce_tc_cmd_t    tc_cmd,         // Run, reset or freeze
  output logic [TC_AW-1:0]        tc_num,         // Timer/counter number
  output logic                    lock_active     // Interlock currently in force
);

  typedef struct packed {
    lce_pkg::lce_phase_t  phase;
    logic [BIT_AW-1:0]    sweep_addr;
    logic                 lock_off;
    logic                 s1_valid;
    logic                 s1_fall;
    logic                 s1_cond;
    logic [BIT_AW-1:0]    s1_bit;
    logic [SLOT_AW-1:0]   s1_slot;
    logic                 tc_valid;
    lce_pkg::lce_tc_cmd_t tc_cmd;
    logic [TC_AW-1:0]     tc_num;
  } lce_state_t;

  localparam logic [BIT_AW-1:0] SWEEP_LAST = {BIT_AW{1'b1}};
  localparam logic [BIT_AW-1:0] SLOT_LAST  = BIT_AW'({SLOT_AW{1'b1}});
  localparam logic [BIT_AW-1:0] ADDR_STEP  = BIT_AW'(1);

  lce_state_t st;
  lce_state_t next_st;

  logic               bit_we;
  logic [BIT_AW-1:0]  bit_wa;
  logic               bit_wd;
  logic               hist_we;
  logic [SLOT_AW-1:0] hist_wa;
  logic               hist_wd;
  logic               hist_rd;
  logic               pulse;
  logic               accept;

  lce_mem #(
    .WIDTH (1),
    .AW    (BIT_AW)
  ) u_bits (
    .clk     (sys_clk),
    .wr_en   (bit_we),
    .wr_addr (bit_wa),
    .wr_data (bit_wd),
    .rd_addr (bit_rd_addr),
    .rd_data (bit_rd_data)
  );

  lce_mem #(
    .WIDTH (1),
    .AW    (SLOT_AW)
  ) u_hist (
    .clk     (sys_clk),
    .wr_en   (hist_we),
    .wr_addr (hist_wa),
    .wr_data (hist_wd),
    .rd_addr (instr_slot),
    .rd_data (hist_rd)
  );

  lce_edge_eval u_edge (
    .falling (st.s1_fall),
    .prev    (hist_rd),
    .cur     (st.s1_cond),
    .pulse   (pulse)
  );

  // Unlocked edge instructions need a history read, so they hold off the next one
  assign instr_ready  = (st.phase == lce_pkg::PH_RUN) && !st.s1_valid;
  assign accept       = instr_valid && instr_ready;
  assign instr_exec   = accept && (instr_op == lce_pkg::OP_OTHER)
                        && !st.lock_off;                          // [RULE11] [RULE15]
  assign lock_active  = st.lock_off;
  assign tc_cmd_valid = st.tc_valid;
  assign tc_cmd       = st.tc_cmd;
  assign tc_num       = st.tc_num;

  always_comb begin
    next_st          = st;
    next_st.tc_valid = 1'b0;
    bit_we           = 1'b0;
    bit_wa           = instr_bit;
    bit_wd           = lce_pkg::BIT_OFF;
    hist_we          = 1'b0;
    hist_wa          = st.s1_slot;
    hist_wd          = st.s1_cond;

    unique case (st.phase)
      lce_pkg::PH_SWEEP: begin
        // Clear volatile bits and edge history; retentive area untouched
        bit_wa  = st.sweep_addr;
        bit_we  = st.sweep_addr < RETAIN_BASE;                    // [RULE9]
        hist_wa = st.sweep_addr[SLOT_AW-1:0];
        hist_wd = lce_pkg::BIT_OFF;
        hist_we = st.sweep_addr <= SLOT_LAST;
        next_st.sweep_addr = st.sweep_addr + ADDR_STEP;
        if (st.sweep_addr == SWEEP_LAST) begin
          next_st.phase = lce_pkg::PH_RUN;
        end
      end
      lce_pkg::PH_RUN: begin
        if (st.s1_valid) begin
          // Pulse written every executed scan, so it lingers only while its section is locked
          bit_we  = 1'b1;                                         // [RULE3]
          bit_wa  = st.s1_bit;
          bit_wd  = pulse;                                        // [RULE1] [RULE4]
          hist_we = 1'b1;                                         // [RULE20]
          next_st.s1_valid = 1'b0;
        end else if (accept) begin
          // No flag outputs exist; none of these kinds can alter flags
          unique case (instr_op)                                  // [RULE22]
            lce_pkg::OP_OUT,
            lce_pkg::OP_OUT_NOT: begin
              bit_we = 1'b1;
              if (st.lock_off) begin
                bit_wd = lce_pkg::BIT_OFF;                        // [RULE12]
              end else begin
                bit_wd = instr_cond ^ (instr_op == lce_pkg::OP_OUT_NOT); // [RULE23]
              end
            end
            lce_pkg::OP_LATCH: begin
              // Locked: no write at all, status maintained
              if (!st.lock_off) begin                             // [RULE8]
                if (instr_cond_rst) begin
                  bit_we = 1'b1;
                  bit_wd = lce_pkg::BIT_OFF;                      // [RULE6] [RULE7]
                end else if (instr_cond) begin
                  bit_we = 1'b1;
                  bit_wd = lce_pkg::BIT_ON;                       // [RULE5]
                end
              end
            end
            lce_pkg::OP_RISE_PULSE,
            lce_pkg::OP_FALL_PULSE: begin
              // Locked: history and bit both left alone
              if (!st.lock_off) begin                             // [RULE15] [RULE19]
                next_st.s1_valid = 1'b1;
                next_st.s1_fall  = instr_op == lce_pkg::OP_FALL_PULSE;
                next_st.s1_cond  = instr_cond;
                next_st.s1_bit   = instr_bit;
                next_st.s1_slot  = instr_slot;
              end
            end
            lce_pkg::OP_SECTION_LOCK: begin
              next_st.lock_off = st.lock_off | ~instr_cond;       // [RULE16] [RULE11]
            end
            lce_pkg::OP_SECTION_UNLK: begin
              next_st.lock_off = 1'b0;                            // [RULE18]
            end
            lce_pkg::OP_DELAY_TIMER: begin
              next_st.tc_valid = 1'b1;
              next_st.tc_num   = instr_tc;
              next_st.tc_cmd   = st.lock_off ? lce_pkg::TC_RESET
                                             : lce_pkg::TC_RUN;   // [RULE13]
            end
            lce_pkg::OP_DOWN_COUNTER: begin
              next_st.tc_valid = 1'b1;
              next_st.tc_num   = instr_tc;
              next_st.tc_cmd   = st.lock_off ? lce_pkg::TC_FREEZE
                                             : lce_pkg::TC_RUN;   // [RULE14]
            end
            default: begin
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st.phase      <= lce_pkg::PH_SWEEP;
      st.sweep_addr <= '0;
      st.lock_off   <= 1'b0;
      st.s1_valid   <= 1'b0;
      st.s1_fall    <= 1'b0;
      st.s1_cond    <= 1'b0;
      st.s1_bit     <= '0;
      st.s1_slot    <= '0;
      st.tc_valid   <= 1'b0;
      st.tc_cmd     <= lce_pkg::TC_RUN;
      st.tc_num     <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule
`default_nettype wire

//--- tb/lce_prog.sv
// Instruction source standing in for the user program
`timescale 1ns/1ps
`default_nettype none
module lce_prog (
  input  wire logic             sys_clk,        // Clock
  input  wire logic             instr_ready,    // Taken when high
  output var  logic             instr_valid,    // Offered
  output var  lce_pkg::lce_op_t instr_op,       // Kind
  output var  logic             instr_cond,     // Condition or set
  output var  logic             instr_cond_rst, // Latch reset
  output var  logic [7:0]       instr_bit,      // Designated bit
  output var  logic [4:0]       instr_slot,     // History slot
  output var  logic [3:0]       instr_tc        // Timer/counter number
);
  // Operands only in output, work, retentive and link areas
  // Every lock closed by an unlock, no step instructions
  initial begin
    {instr_valid, instr_cond, instr_cond_rst, instr_bit, instr_slot, instr_tc} = '0;
    instr_op = lce_pkg::OP_OTHER;
  end
  task automatic issue(input lce_pkg::lce_op_t o, input logic c, input logic r,
                       input logic [7:0] b, input logic [4:0] s, output logic taken);
    int n;
    n = 0;
    @(negedge sys_clk);
    instr_op       = o;
    instr_cond     = c;
    instr_cond_rst = r;
    instr_bit      = b;
    instr_slot     = s;
    instr_valid    = 1'b1;
    while (n < 40) begin
      #1 n = (instr_ready === 1'b1) ? 99 : n + 1;
      @(posedge sys_clk);
      if (n != 99) @(negedge sys_clk);
    end
    // A refused offer is reported, never silently dropped
    taken = (n == 99);
    @(negedge sys_clk);
    instr_valid = 1'b0;
    instr_cond = ~c; // Stale fields must not look meaningful
    instr_tc = instr_tc + 4'h1;
  endtask
endmodule
`default_nettype wire

//--- tb/lce_unit_chk.sv
// Assertions on the unit's instruction and timer/counter ports
`timescale 1ns/1ps
`default_nettype none
module lce_unit_chk #(
  parameter int unsigned TC_AW = lce_pkg::DEF_TC_AW
) (
  input wire logic                 sys_clk,      // Clock
  input wire logic                 resetn,       // Reset, active low
  input wire logic                 instr_valid,  // Offered
  input wire logic                 instr_ready,  // Taken
  input wire lce_pkg::lce_op_t     instr_op,     // Kind
  input wire logic                 instr_cond,   // Condition
  input wire logic [TC_AW-1:0]     instr_tc,     // Timer/counter number offered
  input wire logic                 instr_exec,   // Other executes
  input wire logic                 tc_cmd_valid, // Command strobe
  input wire lce_pkg::lce_tc_cmd_t tc_cmd,       // Command
  input wire logic [TC_AW-1:0]     tc_num,       // Number issued
  input wire logic                 lock_active   // Interlock in force
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire logic tk = instr_valid && instr_ready;
  sequence s_take(lce_pkg::lce_op_t o);
    tk && instr_op == o;
  endsequence
  lock_set_a: assert property (
    s_take(lce_pkg::OP_SECTION_LOCK) ##0 !instr_cond |=> lock_active) else $error("lock missed");
  lock_clear_a: assert property (
    s_take(lce_pkg::OP_SECTION_UNLK) |=> !lock_active) else $error("unlock missed");
  timer_reset_a: assert property (
    s_take(lce_pkg::OP_DELAY_TIMER) ##0 lock_active |=> tc_cmd_valid && tc_cmd == lce_pkg::TC_RESET)
    else $error("locked timer not reset");
  count_freeze_a: assert property (
    s_take(lce_pkg::OP_DOWN_COUNTER) ##0 lock_active |=> tc_cmd_valid && tc_cmd == lce_pkg::TC_FREEZE)
    else $error("locked counter not frozen");
  tc_run_a: assert property (
    tk && !lock_active && instr_op inside {lce_pkg::OP_DELAY_TIMER, lce_pkg::OP_DOWN_COUNTER}
    |=> tc_cmd_valid && tc_cmd == lce_pkg::TC_RUN) else $error("timer/counter not run");
  exec_gate_a: assert property (
    instr_exec == (tk && instr_op == lce_pkg::OP_OTHER && !lock_active)) else $error("exec wrong");
  pulse_stall_a: assert property (
    s_take(lce_pkg::OP_RISE_PULSE) ##0 !lock_active |=> !instr_ready) else $error("no stall");
  tc_strobe_a: assert property (
    tc_cmd_valid |-> $past(tk) && $past(instr_op) inside
    {lce_pkg::OP_DELAY_TIMER, lce_pkg::OP_DOWN_COUNTER}) else $error("stray command");
  lock_hold_a: assert property (
    s_take(lce_pkg::OP_SECTION_LOCK) ##0 lock_active |=> lock_active) else $error("lock dropped");
  tc_number_a: assert property (
    tk && instr_op inside {lce_pkg::OP_DELAY_TIMER, lce_pkg::OP_DOWN_COUNTER}
    |=> tc_num == $past(instr_tc)) else $error("wrong timer/counter number");
endmodule
bind lce_unit lce_unit_chk #(.TC_AW(TC_AW)) lce_unit_chk_inst (.sys_clk, .resetn, .instr_valid,
  .instr_ready, .instr_op, .instr_cond, .instr_tc, .instr_exec, .tc_cmd_valid, .tc_cmd, .tc_num,
  .lock_active);
`default_nettype wire

//--- tb/lce_unit_tb_top.sv
// Self-checking bench for the edge, latch and interlock unit
`timescale 1ns/1ps
`default_nettype none
module lce_unit_tb_top;
  logic sys_clk, resetn, instr_valid, instr_cond, instr_cond_rst, bit_rd_data, p, c;
  logic instr_ready, instr_exec, tc_cmd_valid, lock_active;
  logic [7:0] instr_bit, bit_rd_addr;
  logic [4:0] instr_slot;
  logic [3:0] instr_tc, tc_num;
  lce_pkg::lce_op_t instr_op;
  lce_pkg::lce_tc_cmd_t tc_cmd;
  int bad_count, num_checks, cyc;
  logic [31:0] seed, r;
  logic [17:0] lt = {3'b010, 3'b101, 3'b000, 3'b110, 3'b001, 3'b101};
  lce_unit lce_unit_inst (.sys_clk, .resetn, .instr_valid, .instr_ready, .instr_op, .instr_cond,
    .instr_cond_rst, .instr_bit, .instr_slot, .instr_tc, .instr_exec, .bit_rd_addr,
    .bit_rd_data, .tc_cmd_valid, .tc_cmd, .tc_num, .lock_active);
  lce_prog lce_prog_inst (.sys_clk, .instr_ready, .instr_valid, .instr_op, .instr_cond,
    .instr_cond_rst, .instr_bit, .instr_slot, .instr_tc);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic pulse_f(logic fall, logic pv, logic cv);
    return fall ? (pv & ~cv) : (~pv & cv);
  endfunction
  task automatic check(logic seen, logic exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t value mismatch", $time);
    end
  endtask
  task automatic rd(logic [7:0] a, logic e);
    @(negedge sys_clk);
    bit_rd_addr = a;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    check(bit_rd_data, e);
  endtask
  task automatic boot();
    int n;
    n = 0;
    @(negedge sys_clk);
    resetn = 1'b0;
    repeat (4) @(negedge sys_clk);
    resetn = 1'b1;
    while (instr_ready !== 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
  endtask
  task automatic op(lce_pkg::lce_op_t o, logic cv, logic rv, logic [7:0] b, logic [4:0] s);
    logic taken;
    lce_prog_inst.issue(o, cv, rv, b, s, taken);
    check(taken, 1'b1);
  endtask
  task automatic tcs();
    op(lce_pkg::OP_DELAY_TIMER, 1'b1, 1'b0, 8'h00, 5'h0);
    op(lce_pkg::OP_DOWN_COUNTER, 1'b1, 1'b0, 8'h00, 5'h0);
    op(lce_pkg::OP_OTHER, 1'b1, 1'b0, 8'h00, 5'h0);
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    seed = 32'h25f95b95;
    resetn = 1'b0;
    bit_rd_addr = 8'h00;
    boot();
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      op(r[9] ? lce_pkg::OP_OUT_NOT : lce_pkg::OP_OUT, r[8], 1'b0, {1'b0, r[6:0]}, 5'h0);
      rd({1'b0, r[6:0]}, r[8] ^ r[9]);
    end
    for (int i = 0; i < 6; i++) begin
      op(lce_pkg::OP_LATCH, lt[i*3+2], lt[i*3+1], 8'h20, 5'h0);
      rd(8'h20, lt[i*3]);
    end
    for (int f = 0; f < 2; f++) begin
      p = 1'b0;
      for (int i = 0; i < 5; i++) begin
        c = (i == 1) || (i == 2);
        op(f[0] ? lce_pkg::OP_FALL_PULSE : lce_pkg::OP_RISE_PULSE, c, 1'b0, 8'h30 + 8'(f[0]),
           5'h03 + 5'(f[0]));
        rd(8'h30 + 8'(f[0]), pulse_f(f[0], p, c));
        p = c;
      end
    end
    op(lce_pkg::OP_LATCH, 1'b1, 1'b0, 8'h42, 5'h0);
    op(lce_pkg::OP_RISE_PULSE, 1'b1, 1'b0, 8'h41, 5'h8);
    op(lce_pkg::OP_RISE_PULSE, 1'b1, 1'b0, 8'h41, 5'h8);
    tcs();
    op(lce_pkg::OP_SECTION_LOCK, 1'b1, 1'b0, 8'h00, 5'h0);
    op(lce_pkg::OP_OUT, 1'b1, 1'b0, 8'h43, 5'h0);
    rd(8'h43, 1'b1);
    op(lce_pkg::OP_SECTION_LOCK, 1'b0, 1'b0, 8'h00, 5'h0);
    // A later open lock must not lift the earlier closed one
    op(lce_pkg::OP_SECTION_LOCK, 1'b1, 1'b0, 8'h00, 5'h0);
    op(lce_pkg::OP_OUT, 1'b1, 1'b0, 8'h43, 5'h0);
    rd(8'h43, 1'b0);
    op(lce_pkg::OP_OUT_NOT, 1'b0, 1'b0, 8'h44, 5'h0);
    rd(8'h44, 1'b0);
    op(lce_pkg::OP_LATCH, 1'b0, 1'b1, 8'h42, 5'h0);
    rd(8'h42, 1'b1);
    op(lce_pkg::OP_RISE_PULSE, 1'b0, 1'b0, 8'h41, 5'h8);
    op(lce_pkg::OP_RISE_PULSE, 1'b1, 1'b0, 8'h41, 5'h8);
    rd(8'h41, 1'b0);
    // Last locked condition differs from the one stored before the lock
    op(lce_pkg::OP_RISE_PULSE, 1'b0, 1'b0, 8'h41, 5'h8);
    tcs();
    op(lce_pkg::OP_SECTION_UNLK, 1'b1, 1'b0, 8'h00, 5'h0);
    op(lce_pkg::OP_RISE_PULSE, 1'b1, 1'b0, 8'h41, 5'h8);
    rd(8'h41, 1'b0);
    op(lce_pkg::OP_OUT, 1'b1, 1'b0, 8'h43, 5'h0);
    rd(8'h43, 1'b1);
    op(lce_pkg::OP_LATCH, 1'b1, 1'b0, 8'hc5, 5'h0);
    op(lce_pkg::OP_LATCH, 1'b1, 1'b0, 8'h22, 5'h0);
    boot();
    rd(8'hc5, 1'b1);
    rd(8'h22, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
